// ### src/shift_status_word_packer.sv
// Builds the shift part of the gearbox controller's periodic status message.
// Assumes gear sensing and failure flags come from pins (synchronised here);
// mode and registers come from logic on clk.
//
// Overview of operation
// - Actual mode in bits 61..64, zero to six.
// - Report mode in force, not commanded one.
// - Gear bits 59..60: neutral, low, high, changing.
// - Bit 58 high while changing into high.
// - Bit 57 high while changing into low.
// - Bit 56 shows a neutral engagement (to low or to high) failed.
// - Bit 55 shows a disengagement (low or high to neutral) failed.
// - Pressure fault forces upshift-failure bit, latch untouched.
// - Pressure fault forces downshift-failure bit, latch untouched.
// - Single neutral engagement failure gives one-second pulse.
// - Both neutral engagement failures latch upshift failure.
// - Any disengagement failure latches downshift failure.
// - Upshift failure holds gear, ignores commanded mode.
// - Downshift failure holds gear, ignores commanded mode.
`timescale 1ns/1ps
`default_nettype none
module shift_status_word_packer
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [3:0]  commanded_mode,  // Mode requested by the far party.
   input  wire logic        mode_allowed,    // Conditions permit a mode change.
   input  wire logic        in_neutral,      // Pin: neutral sensed.
   input  wire logic        in_low,          // Pin: low engaged.
   input  wire logic        in_high,         // Pin: high engaged.
   input  wire logic        moving_to_high,  // Pin: actuator driving into high.
   input  wire logic        moving_to_low,   // Pin: actuator driving into low.
   input  wire logic        fail_n_to_low,   // Pin: neutral-to-low failed.
   input  wire logic        fail_n_to_high,  // Pin: neutral-to-high failed.
   input  wire logic        fail_low_to_n,   // Pin: low-to-neutral failed.
   input  wire logic        fail_high_to_n,  // Pin: high-to-neutral failed.
   input  wire logic        air_out_of_range, // Pin: air pressure fault.
   input  wire logic [1:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic [31:0]      rdata,
   output logic             irq,
   output logic [64:1]      status_msg,      // Payload, bit n is field bit n.
   output logic             gear_hold        // Limp-home: keep present gear.
);
   // -------------------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------------------
   localparam int NPIN = 10;
   logic [NPIN-1:0] pin_raw;   // Raw pins in a fixed order.
   logic [NPIN-1:0] pin_s;     // Synchronised pins.
   assign pin_raw = {air_out_of_range, fail_high_to_n, fail_low_to_n, fail_n_to_high,
                     fail_n_to_low, moving_to_low, moving_to_high, in_high, in_low, in_neutral};

   // Each pin crosses through two flops before any logic reads it.
   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++)
      begin : g_sync
         sync2 u_sync (.clk(clk), .rstn(rstn), .d(pin_raw[gi]), .q(pin_s[gi]));
      end
   endgenerate

   logic s_neu, s_low, s_high, s_to_high, s_to_low;
   logic s_fnl, s_fnh, s_fln, s_fhn, s_air;
   assign {s_air, s_fhn, s_fln, s_fnh, s_fnl, s_to_low, s_to_high, s_high, s_low, s_neu} = pin_s;

   // -------------------------------------------------------------------------
   // Failure latches and limp-home hold
   // -------------------------------------------------------------------------
   logic up_latch_reg, up_latch_next;      // Upshift failure latched.
   logic dn_latch_reg, dn_latch_next;      // Downshift failure latched.
   logic hold_reg, hold_next;              // Gear hold in force.
   logic single_fail_prev_reg, single_fail_prev_next; // For rising edge.
   logic single_fail;                      // Exactly one neutral engagement failed.
   logic pulse_start;                      // Starts the one-second pulse.
   logic pulse_on;                         // One-second pulse running.

   assign single_fail = s_fnl ^ s_fnh;
   assign pulse_start = single_fail && !single_fail_prev_reg;

   // The one-second window is counted on clk; no prescaler is needed.
   pulse_timer #(.CYCLES(shift_pkg::PULSE_CYCLES)) u_pulse
   (
      .clk   (clk),
      .rstn  (rstn),
      .start (pulse_start),
      .active(pulse_on)
   );

   // Latches only ever set; nothing but reset clears them.
   always_comb
   begin
      single_fail_prev_next = single_fail;
      up_latch_next = up_latch_reg | (s_fnl & s_fnh);
      dn_latch_next = dn_latch_reg | s_fln | s_fhn;
      hold_next = hold_reg | up_latch_next | dn_latch_next | pulse_start;
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         up_latch_reg         <= 1'b0;
         dn_latch_reg         <= 1'b0;
         hold_reg             <= 1'b0;
         single_fail_prev_reg <= 1'b0;
      end
      else
      begin
         up_latch_reg         <= up_latch_next;
         dn_latch_reg         <= dn_latch_next;
         hold_reg             <= hold_next;
         single_fail_prev_reg <= single_fail_prev_next;
      end
   end

   // -------------------------------------------------------------------------
   // Mode in force
   // -------------------------------------------------------------------------
   logic [3:0] mode_reg, mode_next;  // Mode actually applied.

   // A command takes effect only when legal, permitted and not in limp-home.
   always_comb
   begin
      mode_next = mode_reg;
      if (mode_allowed && !hold_reg && commanded_mode <= shift_pkg::MODE_MAX)
         mode_next = commanded_mode;
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
         mode_reg <= 4'h0;
      else
         mode_reg <= mode_next;
   end

   // -------------------------------------------------------------------------
   // Message assembly
   // -------------------------------------------------------------------------
   logic [1:0]  gear_code;
   logic        up_fail_out, dn_fail_out;
   logic [64:1] msg_next, msg_reg;

   always_comb
   begin
      if (s_to_high || s_to_low)
         gear_code = shift_pkg::GEAR_CHANGING;
      else if (s_high)
         gear_code = shift_pkg::GEAR_HIGH;
      else if (s_low)
         gear_code = shift_pkg::GEAR_LOW;
      else
         gear_code = shift_pkg::GEAR_NEUTRAL;
   end

   assign up_fail_out = up_latch_reg | pulse_on | s_air;
   assign dn_fail_out = dn_latch_reg | s_air;

   always_comb
   begin
      msg_next = '0;
      msg_next[shift_pkg::MODE_MSB:shift_pkg::MODE_LSB] = mode_reg;
      msg_next[shift_pkg::GEAR_MSB:shift_pkg::GEAR_LSB] = gear_code;
      msg_next[shift_pkg::UP_ACT_BIT]  = s_to_high;
      msg_next[shift_pkg::DN_ACT_BIT]  = s_to_low;
      msg_next[shift_pkg::UP_FAIL_BIT] = up_fail_out;
      msg_next[shift_pkg::DN_FAIL_BIT] = dn_fail_out;
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
         msg_reg <= '0;
      else
         msg_reg <= msg_next;
   end

   assign status_msg = msg_reg;
   assign gear_hold  = hold_reg;

   // -------------------------------------------------------------------------
   // Interrupts and register port
   // -------------------------------------------------------------------------
   logic [3:0] ev;                     // One-cycle events.
   logic [3:0] sts_reg, sts_next;      // Sticky status.
   logic [3:0] en_reg, en_next;        // Enable mask.
   logic [31:0] rdata_reg, rdata_next;
   logic       prev_up_act_reg, prev_dn_act_reg;

   assign ev[shift_pkg::IRQ_UP_FAIL] = up_fail_out & ~msg_reg[shift_pkg::UP_FAIL_BIT];
   assign ev[shift_pkg::IRQ_DN_FAIL] = dn_fail_out & ~msg_reg[shift_pkg::DN_FAIL_BIT];
   assign ev[shift_pkg::IRQ_UP_DONE] = prev_up_act_reg & ~s_to_high;
   assign ev[shift_pkg::IRQ_DN_DONE] = prev_dn_act_reg & ~s_to_low;

   // Set wins over a clear arriving in the same cycle.
   always_comb
   begin
      sts_next   = sts_reg;
      en_next    = en_reg;
      rdata_next = 32'h0;
      if (wr && addr == shift_pkg::ADDR_CLEAR)
         sts_next = sts_reg & ~wdata[3:0];
      if (wr && addr == shift_pkg::ADDR_ENABLE)
         en_next = wdata[3:0];
      sts_next = sts_next | ev;
      if (rd)
      begin
         case (addr)
            shift_pkg::ADDR_STATUS: rdata_next = {28'h0, sts_reg};
            shift_pkg::ADDR_ENABLE: rdata_next = {28'h0, en_reg};
            shift_pkg::ADDR_MSG_HI: rdata_next = msg_reg[64:33];
            default:                rdata_next = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         sts_reg         <= 4'h0;
         en_reg          <= 4'h0;
         rdata_reg       <= 32'h0;
         prev_up_act_reg <= 1'b0;
         prev_dn_act_reg <= 1'b0;
      end
      else
      begin
         sts_reg         <= sts_next;
         en_reg          <= en_next;
         rdata_reg       <= rdata_next;
         prev_up_act_reg <= s_to_high;
         prev_dn_act_reg <= s_to_low;
      end
   end

   assign rdata = rdata_reg;
   assign irq   = |(sts_reg & en_reg);

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   a_mode_range:   assert property (status_msg[64:61] <= shift_pkg::MODE_MAX)
      else $error("mode field out of range");
   a_mode_hold:    assert property (hold_reg |=> $stable(mode_reg))
      else $error("mode changed during hold");
   a_gear_change:  assert property ((s_to_high || s_to_low) |=> status_msg[60:59] == 2'h3)
      else $error("gear not shown changing");
   a_up_active:    assert property (##1 status_msg[58] == $past(s_to_high))
      else $error("upshift flag wrong");
   a_dn_active:    assert property (##1 status_msg[57] == $past(s_to_low))
      else $error("downshift flag wrong");
   a_air_up:       assert property (s_air |=> status_msg[56])
      else $error("pressure did not force upshift bit");
   a_air_dn:       assert property (s_air |=> status_msg[55] && $stable(dn_latch_reg))
      else $error("pressure did not force downshift bit");
   a_up_latch:     assert property ((s_fnl && s_fnh) |=> up_latch_reg ##1 up_latch_reg)
      else $error("upshift latch not set");
   a_dn_latch:     assert property ((s_fln || s_fhn) |=> dn_latch_reg)
      else $error("downshift latch not set");
   a_pulse_on:     assert property (pulse_start |=> pulse_on [*8])
      else $error("failure pulse too short");
   a_hold_sticky:  assert property (hold_reg |=> hold_reg)
      else $error("gear hold dropped");
   a_hold_dn:      assert property (dn_latch_reg |-> hold_reg)
      else $error("downshift failure without hold");
   a_hold_up:      assert property (up_latch_reg |-> hold_reg)
      else $error("upshift failure without hold");
   // A clean history must read as success, so a stuck failure view shows up here.
   a_up_fail_zero: assert property ((!up_latch_reg && !pulse_on && !s_air) |=> !status_msg[56])
      else $error("upshift failure shown without cause");
   a_dn_fail_zero: assert property ((!dn_latch_reg && !s_air) |=> !status_msg[55])
      else $error("downshift failure shown without cause");
   a_gear_neutral: assert property ((s_neu && !s_low && !s_high && !s_to_high && !s_to_low) |=> status_msg[60:59] == 2'h0)
      else $error("neutral not shown as zero");
   a_word_zero:    assert property (status_msg[54:1] == 54'h0)
      else $error("fields outside this block not zero");

   c_pulse:  cover property (pulse_start);
   c_upl:    cover property (up_latch_reg);
   c_air:    cover property (s_air ##1 !s_air);
   c_irq:    cover property (irq);
   c_dnl:    cover property (dn_latch_reg);
endmodule
`default_nettype wire

// ### inc/shift_pkg.sv
// Constants for the gear-shift status word packer.
// Assumes a single 10 MHz clock domain; no surroundings beyond the package users.
package shift_pkg;
   // -------------------------------------------------------------------------
   // Message field positions (bit numbers counted from 1 within the payload)
   // -------------------------------------------------------------------------
   localparam int MSG_W          = 64;   // Payload width in bits.
   localparam int MODE_LSB       = 61;   // Actual mode field low bit.
   localparam int MODE_MSB       = 64;   // Actual mode field high bit.
   localparam int GEAR_LSB       = 59;   // Engaged gear field low bit.
   localparam int GEAR_MSB       = 60;   // Engaged gear field high bit.
   localparam int UP_ACT_BIT     = 58;   // Upshift in progress.
   localparam int DN_ACT_BIT     = 57;   // Downshift in progress.
   localparam int UP_FAIL_BIT    = 56;   // Upshift failed.
   localparam int DN_FAIL_BIT    = 55;   // Downshift failed.
   localparam logic [3:0] MODE_MAX = 4'h6; // Highest legal mode code.

   // -------------------------------------------------------------------------
   // Gear codes
   // -------------------------------------------------------------------------
   localparam logic [1:0] GEAR_NEUTRAL  = 2'h0;
   localparam logic [1:0] GEAR_LOW      = 2'h1;
   localparam logic [1:0] GEAR_HIGH     = 2'h2;
   localparam logic [1:0] GEAR_CHANGING = 2'h3;

   // -------------------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------------------
   localparam int CLK_HZ       = 10_000_000;  // Clock rate.
   localparam int PULSE_MS     = 1000;        // Failure pulse length in ms.
   localparam int PULSE_CYCLES = (CLK_HZ / 1000) * PULSE_MS;

   // -------------------------------------------------------------------------
   // Interrupt status layout
   // -------------------------------------------------------------------------
   localparam int IRQ_W       = 4;
   localparam int IRQ_UP_FAIL = 0;   // Upshift failure event.
   localparam int IRQ_DN_FAIL = 1;   // Downshift failure event.
   localparam int IRQ_UP_DONE = 2;   // Upshift completed.
   localparam int IRQ_DN_DONE = 3;   // Downshift completed.
   localparam logic [1:0] ADDR_STATUS = 2'h0;  // Read-only sticky status.
   localparam logic [1:0] ADDR_ENABLE = 2'h1;  // Read/write enable.
   localparam logic [1:0] ADDR_CLEAR  = 2'h2;  // Write-one-to-clear.
   localparam logic [1:0] ADDR_MSG_HI = 2'h3;  // Upper message word read back.
endpackage

// ### src/sync2.sv
// Two-flop synchroniser for one asynchronous level.
// Assumes the destination clock is clk with synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module sync2
(
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic d,
   output logic      q
);
   // First stage, read only by the second stage.
   logic meta_reg;
   logic meta_next;
   logic q_reg;
   logic q_next;

   // Next values simply shift the level along.
   always_comb
   begin
      meta_next = d;
      q_next    = meta_reg;
   end

   // Both stages clear on reset.
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         meta_reg <= 1'b0;
         q_reg    <= 1'b0;
      end
      else
      begin
         meta_reg <= meta_next;
         q_reg    <= q_next;
      end
   end

   assign q = q_reg;
endmodule
`default_nettype wire

// ### src/pulse_timer.sv
// Retriggerable one-shot: holds its output for a fixed count after a start pulse.
// Assumes start is already on the clk domain.
`timescale 1ns/1ps
`default_nettype none
module pulse_timer #(parameter int CYCLES = 10)
(
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic start,
   output logic      active
);
   // -------------------------------------------------------------------------
   // Counter
   // -------------------------------------------------------------------------
   logic [31:0] cnt_reg;   // Cycles left in the pulse.
   logic [31:0] cnt_next;

   // A new start restarts the full length, so overlapping failures extend it.
   always_comb
   begin
      if (start)
         cnt_next = 32'(CYCLES);
      else if (cnt_reg != 32'h0)
         cnt_next = cnt_reg - 32'h1;
      else
         cnt_next = cnt_reg;
   end

   // Register only.
   always_ff @(posedge clk)
   begin
      if (!rstn)
         cnt_reg <= 32'h0;
      else
         cnt_reg <= cnt_next;
   end

   assign active = (cnt_reg != 32'h0);
endmodule
`default_nettype wire

// ### verif/traction_reader.sv
// Far-side model: the traction controller that unpacks the status payload.
// Assumes the payload is presented as a 64-bit vector numbered 64 down to 1.
`timescale 1ns/1ps
`default_nettype none
module traction_reader
(
   input  wire logic        clk,
   input  wire logic [64:1] status_msg,
   output logic [3:0]       mode_f,
   output logic [1:0]       gear_f,
   output logic             up_act_f,
   output logic             dn_act_f,
   output logic             up_fail_f,
   output logic             dn_fail_f
);
   // ------------------------------------------------------------------
   // Field unpacking
   // ------------------------------------------------------------------
   // The reader takes raw fields with no offset or scaling, so any scaling
   // slip in the packer shows up directly as a wrong field value.
   // raw field slices
   always_comb
   begin
      mode_f    = status_msg[64:61];
      gear_f    = status_msg[60:59];
      up_act_f  = status_msg[58];
      dn_act_f  = status_msg[57];
      up_fail_f = status_msg[56];
      dn_fail_f = status_msg[55];
   end
endmodule
`default_nettype wire

// ### verif/testbench.sv
// Self-checking bench for the shift status word packer.
// Assumes a 100 ns clock, synchronous active-low reset and fixed pin latency.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        clk, rstn, mode_allowed, wr, rd, irq, gear_hold;
   logic        in_neutral, in_low, in_high, moving_to_high, moving_to_low;
   logic        fail_n_to_low, fail_n_to_high, fail_low_to_n, fail_high_to_n;
   logic        air_out_of_range, up_act_f, dn_act_f, up_fail_f, dn_fail_f;
   logic [3:0]  commanded_mode, mode_f;
   logic [1:0]  addr, gear_f;
   logic [31:0] wdata, rdata, d;
   logic [64:1] status_msg;
   logic [4:0]  pat [5];  // Pin patterns: neutral, low, high, to-high, to-low.
   logic [3:0]  exg [5];  // Expected {gear, up active, down active}.
   int          miscompares, checks_done;

   shift_status_word_packer dut_u (.clk(clk), .rstn(rstn), .commanded_mode(commanded_mode),
      .mode_allowed(mode_allowed), .in_neutral(in_neutral), .in_low(in_low), .in_high(in_high),
      .moving_to_high(moving_to_high), .moving_to_low(moving_to_low), .fail_n_to_low(fail_n_to_low),
      .fail_n_to_high(fail_n_to_high), .fail_low_to_n(fail_low_to_n), .fail_high_to_n(fail_high_to_n),
      .air_out_of_range(air_out_of_range), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .irq(irq), .status_msg(status_msg), .gear_hold(gear_hold));

   traction_reader reader_u (.clk(clk), .status_msg(status_msg), .mode_f(mode_f), .gear_f(gear_f),
      .up_act_f(up_act_f), .dn_act_f(dn_act_f), .up_fail_f(up_fail_f), .dn_fail_f(dn_fail_f));

   // ------------------------------------------------------------------
   // Clock and helpers
   // ------------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Pins reach the payload three edges after they move, failure pins four; six leaves margin.
   task automatic settle();
      tick(6);
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic reg_wr(input logic [1:0] a, input logic [31:0] v);
      @(posedge clk);
      addr  <= a;
      wdata <= v;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so sample just then.
   task automatic reg_rd(input logic [1:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1 v = rdata;
   endtask

   task automatic do_reset(input int n);
      @(posedge clk);
      rstn <= 1'b0;
      tick(n);
      rstn <= 1'b1;
      tick(2);
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // A hang is cut short here and counted as a mismatch.
   initial
   begin
      tick(60000);
      miscompares++;
      final_report();
   end

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial
   begin
      miscompares = 0;
      checks_done = 0;
      rstn = 1'b0;
      {mode_allowed, wr, rd, commanded_mode, addr, wdata} = '0;
      {in_neutral, in_low, in_high, moving_to_high, moving_to_low} = 5'h10;
      {fail_n_to_low, fail_n_to_high, fail_low_to_n, fail_high_to_n, air_out_of_range} = 5'h00;
      pat = '{5'h10, 5'h08, 5'h04, 5'h12, 5'h11};
      exg = '{4'h0, 4'h4, 4'h8, 4'hE, 4'hD};
      tick(20);
      rstn <= 1'b1;
      tick(2);
      check("msg hi", status_msg[64:33], 32'h0);
      check("hold", gear_hold, 32'h0);
      check("irq", irq, 32'h0);
      check("msg lo", status_msg[32:1], 32'h0);
      $display("test reset done");
      mode_allowed <= 1'b1;
      for (int m = 0; m <= 6; m++)
      begin
         commanded_mode <= m[3:0];
         settle();
         check("mode", mode_f, m);
      end
      mode_allowed   <= 1'b0;
      commanded_mode <= 4'h3;
      settle();
      check("mode blocked", mode_f, 32'h6);
      mode_allowed   <= 1'b1;
      commanded_mode <= 4'h7;
      settle();
      check("mode illegal", mode_f, 32'h6);
      reg_rd(2'h3, d);
      check("word mode", d, 32'h60000000);
      $display("test mode done");
      for (int i = 0; i < 5; i++)
      begin
         {in_neutral, in_low, in_high, moving_to_high, moving_to_low} <= pat[i];
         settle();
         check("gear", {gear_f, up_act_f, dn_act_f}, exg[i]);
      end
      {in_neutral, in_low, in_high, moving_to_high, moving_to_low} <= 5'h10;
      air_out_of_range <= 1'b1;
      settle();
      check("air on", {up_fail_f, dn_fail_f}, 32'h3);
      air_out_of_range <= 1'b0;
      settle();
      check("air off", {up_fail_f, dn_fail_f}, 32'h0);
      // Both shift ends and the one pressure rise, on both failure bits, have left their sticky bits.
      reg_rd(2'h0, d);
      check("stat all", d, 32'hF);
      reg_wr(2'h2, 32'hF);
      reg_rd(2'h0, d);
      check("stat cleared", d, 32'h0);
      $display("test gear and air done");
      fail_n_to_low <= 1'b1;
      settle();
      fail_n_to_low <= 1'b0;
      settle();
      check("up pulse", up_fail_f, 32'h1);
      check("hold", gear_hold, 32'h1);
      check("irq masked", irq, 32'h0);
      commanded_mode <= 4'h2;
      settle();
      check("mode held", mode_f, 32'h6);
      reg_rd(2'h0, d);
      check("stat up", d, 32'h1);
      reg_wr(2'h1, 32'h1);
      reg_rd(2'h1, d);
      check("enable rd", d, 32'h1);
      tick(1);
      check("irq on", irq, 32'h1);
      reg_wr(2'h2, 32'h1);
      tick(1);
      check("irq clr", irq, 32'h0);
      do_reset(2);
      check("up cleared", {up_fail_f, gear_hold}, 32'h0);
      $display("test single failure done");
      {fail_n_to_low, fail_n_to_high} <= 2'h3;
      settle();
      {fail_n_to_low, fail_n_to_high} <= 2'h0;
      air_out_of_range <= 1'b1;
      settle();
      air_out_of_range <= 1'b0;
      settle();
      check("up latch", up_fail_f, 32'h1);
      do_reset(2);
      check("latch cleared", up_fail_f, 32'h0);
      $display("test both failures done");
      for (int i = 0; i < 2; i++)
      begin
         {fail_low_to_n, fail_high_to_n} <= (i == 0) ? 2'h2 : 2'h1;
         settle();
         {fail_low_to_n, fail_high_to_n} <= 2'h0;
         settle();
         check("dn latch", dn_fail_f, 32'h1);
         check("dn hold", gear_hold, 32'h1);
         reg_rd(2'h0, d);
         check("stat dn", d[1], 32'h1);
         do_reset(2);
         check("dn cleared", {dn_fail_f, gear_hold}, 32'h0);
      end
      $display("test disengage failures done");
      reg_wr(2'h0, 32'hF);
      reg_rd(2'h0, d);
      check("status ro", d, 32'h0);
      reg_rd(2'h2, d);
      check("clear rd", d, 32'h0);
      $display("test registers done");
      final_report();
   end
endmodule
`default_nettype wire
